// *** pgas_pkg.sv ***
// Package for the eight-pin port with analog select: register map,
// field positions, reset values.
// Assumes the classic Wishbone slave of the port module and its test bench are its only users.

package pgas_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indexes, byte address is four times the index
    localparam logic [7:0] IDX_PORT_PIN_DATA      = 8'h05;
    localparam logic [7:0] IDX_PORT_PIN_DIRECTION = 8'h85;
    localparam logic [7:0] IDX_ANALOG_PIN_SELECT  = 8'h9D;
    localparam logic [7:0] IDX_OSC_STATUS         = 8'hA0;

    ////////////////////////////////////////////////////////////////////////
    // Widths and field positions
    localparam int PORT_W        = 8;
    localparam int ANALOG_PIN_SELECT_W       = 6;
    localparam int LOW_PINS      = 4;
    localparam int OPEN_DRAIN    = 4;
    localparam int INPUT_ONLY    = 5;
    localparam int OSC_OUT_PIN   = 6;
    localparam int OSC_IN_PIN    = 7;
    localparam int WR_MASK_LSB   = 8;
    localparam int WR_MASK_LANE  = 1;
    localparam int ADR_W         = 10;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and the full write mask
    localparam logic [3:0]         DATA_LOW_RST  = 4'h0;
    localparam logic [PORT_W-1:0]  DIR_RST       = 8'hFF;
    localparam logic [ANALOG_PIN_SELECT_W-1:0] ANALOG_PIN_SELECT_RST     = 6'h3F;
    localparam logic [PORT_W-1:0]  FULL_MASK     = 8'hFF;

endpackage

// *** pgas_port.sv ***
// Port A: eight pins with direction, output latch, pin read and
// analog select, reached over a classic Wishbone slave.
// Assumes pad logic resolves each pin from PIN_OUT and PIN_OE_N and
// that OSC_OWNS_PINS is a static level from the oscillator setup.
//
// The implementer's own choice: register access over Wishbone.

`timescale 1ns/100ps

module pgas_port (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // Wishbone slave
    input  wire logic        WB_CYC,
    input  wire logic        WB_STB,
    input  wire logic        WB_WE,
    input  wire logic [9:0]  WB_ADR,
    input  wire logic [3:0]  WB_SEL,
    input  wire logic [31:0] WB_DAT_W,
    output logic      [31:0] WB_DAT_R,
    output logic             WB_ACK,
    // Pins
    input  wire logic [7:0]  PIN_IN,
    output logic      [7:0]  PIN_OUT,
    output logic      [7:0]  PIN_OE_N,
    // Oscillator and alternate functions
    input  wire logic        OSC_OWNS_PINS,
    output logic             TIMER_ZERO_CLK,
    output logic             MASTER_CLEAR_LEVEL,
    output logic      [5:0]  ANALOG_SEL
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0]  pin_meta_q;
    logic [7:0]  pin_sync_q;
    logic        osc_meta_q;
    logic        osc_sync_q;
    logic [7:0]  latch_q;
    logic [3:0]  latch_lo_q;
    logic [3:0]  latch_hi_q;
    logic [7:0]  latch_d;
    logic [7:0]  dir_q;
    logic [5:0]  analog_pin_select_q;
    logic [7:0]  pin_read;
    logic [7:0]  wmask;
    logic [7:0]  out_d;
    logic [7:0]  oe_n_d;
    logic [31:0] rdata;
    logic        req;
    logic        wr_take;
    logic [7:0]  idx;

    assign idx     = WB_ADR[9:2];
    assign req     = WB_CYC && WB_STB;
    assign wr_take = req && WB_WE && WB_ACK;
    assign latch_q = {latch_hi_q, latch_lo_q};

    ////////////////////////////////////////////////////////////////////////
    // Pin and oscillator synchronisers
    always_ff @(posedge CLK) begin
        pin_meta_q <= PIN_IN;
        pin_sync_q <= pin_meta_q;
        osc_meta_q <= OSC_OWNS_PINS;
        osc_sync_q <= osc_meta_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin read path
    always_comb begin
        pin_read = pin_sync_q;
        for (int i = 0; i < pgas_pkg::LOW_PINS; i++) begin
            if (analog_pin_select_q[i]) begin
                pin_read[i] = 1'b0;
            end
        end
        if (osc_sync_q) begin
            pin_read[pgas_pkg::OSC_OUT_PIN] = 1'b0;
            pin_read[pgas_pkg::OSC_IN_PIN]  = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output latch
    always_comb begin
        wmask = pgas_pkg::FULL_MASK;
        if (WB_SEL[pgas_pkg::WR_MASK_LANE]) begin
            wmask = WB_DAT_W[pgas_pkg::WR_MASK_LSB +: pgas_pkg::PORT_W];
        end
        latch_d = (pin_read & ~wmask) | (WB_DAT_W[7:0] & wmask);
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            latch_lo_q <= pgas_pkg::DATA_LOW_RST;
        end else if (wr_take && WB_SEL[0] && idx == pgas_pkg::IDX_PORT_PIN_DATA) begin
            latch_lo_q <= latch_d[3:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (wr_take && WB_SEL[0] && idx == pgas_pkg::IDX_PORT_PIN_DATA) begin
            latch_hi_q <= latch_d[7:4];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Direction and analog select
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            dir_q <= pgas_pkg::DIR_RST;
        end else if (wr_take && WB_SEL[0] && idx == pgas_pkg::IDX_PORT_PIN_DIRECTION) begin
            dir_q <= WB_DAT_W[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            analog_pin_select_q <= pgas_pkg::ANALOG_PIN_SELECT_RST;
        end else if (wr_take && WB_SEL[0] && idx == pgas_pkg::IDX_ANALOG_PIN_SELECT) begin
            analog_pin_select_q <= WB_DAT_W[pgas_pkg::ANALOG_PIN_SELECT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers
    always_comb begin
        for (int i = 0; i < pgas_pkg::PORT_W; i++) begin
            out_d[i]  = latch_q[i];
            oe_n_d[i] = dir_q[i];
        end
        out_d[pgas_pkg::OPEN_DRAIN]  = 1'b0;
        oe_n_d[pgas_pkg::OPEN_DRAIN] = dir_q[pgas_pkg::OPEN_DRAIN]
                                       || latch_q[pgas_pkg::OPEN_DRAIN];
        out_d[pgas_pkg::INPUT_ONLY]  = 1'b0;
        oe_n_d[pgas_pkg::INPUT_ONLY] = 1'b1;
        if (osc_sync_q) begin
            oe_n_d[pgas_pkg::OSC_OUT_PIN] = 1'b1;
            oe_n_d[pgas_pkg::OSC_IN_PIN]  = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            PIN_OUT  <= 8'h00;
            PIN_OE_N <= 8'hFF;
        end else begin
            PIN_OUT  <= out_d;
            PIN_OE_N <= oe_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alternate function outputs
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            TIMER_ZERO_CLK     <= 1'b0;
            MASTER_CLEAR_LEVEL <= 1'b1;
            ANALOG_SEL         <= pgas_pkg::ANALOG_PIN_SELECT_RST;
        end else begin
            TIMER_ZERO_CLK     <= pin_sync_q[pgas_pkg::OPEN_DRAIN];
            MASTER_CLEAR_LEVEL <= pin_sync_q[pgas_pkg::INPUT_ONLY];
            ANALOG_SEL         <= analog_pin_select_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone read mux and acknowledge
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (idx)
            pgas_pkg::IDX_PORT_PIN_DATA:      rdata[7:0] = pin_read;
            pgas_pkg::IDX_PORT_PIN_DIRECTION: rdata[7:0] = dir_q;
            pgas_pkg::IDX_ANALOG_PIN_SELECT:  rdata[5:0] = analog_pin_select_q;
            pgas_pkg::IDX_OSC_STATUS:         rdata[0]   = osc_sync_q;
            default:                          rdata      = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            WB_ACK   <= 1'b0;
            WB_DAT_R <= 32'h0000_0000;
        end else begin
            WB_ACK   <= req && !WB_ACK;
            WB_DAT_R <= (req && !WB_ACK && !WB_WE) ? rdata : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    AST_DIR_INPUT: assert property (@(posedge CLK) disable iff (!RST_N)
        dir_q[0] |=> PIN_OE_N[0])
        else $error("input pin is driven");

    AST_DIR_OUTPUT: assert property (@(posedge CLK) disable iff (!RST_N)
        !dir_q[1] |=> !PIN_OE_N[1] && PIN_OUT[1] == $past(latch_q[1]))
        else $error("output pin not driven from latch");

    AST_READ_PINS: assert property (@(posedge CLK) disable iff (!RST_N)
        req && !WB_WE && !WB_ACK && idx == pgas_pkg::IDX_PORT_PIN_DATA
        |=> WB_ACK && WB_DAT_R[7:0] == $past(pin_read))
        else $error("data read does not return pins");

    AST_RMW: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_take && WB_SEL[0] && idx == pgas_pkg::IDX_PORT_PIN_DATA
        |=> latch_q == (($past(pin_read) & ~$past(wmask))
                        | ($past(WB_DAT_W[7:0]) & $past(wmask))))
        else $error("merge write wrong");

    AST_RESET_VALUES: assert property (@(posedge CLK)
        !RST_N |=> analog_pin_select_q == pgas_pkg::ANALOG_PIN_SELECT_RST && dir_q == pgas_pkg::DIR_RST
                   && latch_q[3:0] == pgas_pkg::DATA_LOW_RST)
        else $error("reset values wrong");

    AST_ANALOG_ZERO: assert property (@(posedge CLK) disable iff (!RST_N)
        req && !WB_WE && !WB_ACK && idx == pgas_pkg::IDX_PORT_PIN_DATA && analog_pin_select_q[2]
        |=> WB_DAT_R[2] == 1'b0)
        else $error("analog pin reads nonzero");

    AST_OPEN_DRAIN: assert property (@(posedge CLK) disable iff (!RST_N)
        !PIN_OE_N[4] |-> !PIN_OUT[4] && $past(!latch_q[4] && !dir_q[4]))
        else $error("open drain pin drives high");

    AST_INPUT_ONLY: assert property (@(posedge CLK) disable iff (!RST_N)
        PIN_OE_N[5] && !PIN_OUT[5])
        else $error("input only pin driven");

    AST_OSC_PINS: assert property (@(posedge CLK) disable iff (!RST_N)
        osc_sync_q |=> PIN_OE_N[7:6] == 2'b11)
        else $error("oscillator pins driven");

    AST_ANALOG_PIN_SELECT_READ: assert property (@(posedge CLK) disable iff (!RST_N)
        req && !WB_WE && !WB_ACK && idx == pgas_pkg::IDX_ANALOG_PIN_SELECT
        |=> WB_DAT_R[7:0] == {2'b00, $past(analog_pin_select_q)})
        else $error("select register read wrong");

    AST_LATCH_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
        !(wr_take && idx == pgas_pkg::IDX_PORT_PIN_DATA) |=> $stable(latch_q))
        else $error("latch changed without write");

    AST_PUSH_PULL_HIGH: assert property (@(posedge CLK) disable iff (!RST_N)
        !dir_q[3] && latch_q[3] |=> !PIN_OE_N[3] && PIN_OUT[3])
        else $error("push-pull pin does not drive high");

    AST_OSC_FREE: assert property (@(posedge CLK) disable iff (!RST_N)
        !osc_sync_q && !dir_q[6] |=> !PIN_OE_N[6] && PIN_OUT[6] == $past(latch_q[6]))
        else $error("free oscillator pin not driven from latch");

    AST_ANALOG_DIR: assert property (@(posedge CLK) disable iff (!RST_N)
        analog_pin_select_q[0] && !dir_q[0] |=> !PIN_OE_N[0])
        else $error("direction lost control of analog pin");

    AST_ANALOG_BUFFER: assert property (@(posedge CLK) disable iff (!RST_N)
        (pin_read[3:0] & analog_pin_select_q[3:0]) == 4'h0)
        else $error("analog pin digital buffer not disabled");

    AST_ANALOG_PIN_SELECT_OUT: assert property (@(posedge CLK) disable iff (!RST_N)
        1'b1 |=> ANALOG_SEL == $past(analog_pin_select_q))
        else $error("select output does not follow register");

    AST_TIMER_FEED: assert property (@(posedge CLK) disable iff (!RST_N)
        1'b1 |=> TIMER_ZERO_CLK == $past(pin_sync_q[pgas_pkg::OPEN_DRAIN]))
        else $error("timer zero clock not fed from pin");

    AST_CLEAR_FEED: assert property (@(posedge CLK) disable iff (!RST_N)
        1'b1 |=> MASTER_CLEAR_LEVEL == $past(pin_sync_q[pgas_pkg::INPUT_ONLY]))
        else $error("master clear level not fed from pin");

    AST_DIR_WRITE: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_take && WB_SEL[0] && idx == pgas_pkg::IDX_PORT_PIN_DIRECTION
        |=> dir_q == $past(WB_DAT_W[7:0]))
        else $error("direction write lost");

    AST_LANE_GATE: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_take && !WB_SEL[0] |=> $stable(dir_q) && $stable(analog_pin_select_q))
        else $error("write with low lane off changed a register");

    AST_ACK_ANSWER: assert property (@(posedge CLK) disable iff (!RST_N)
        req && !WB_ACK |=> WB_ACK)
        else $error("request not answered in one cycle");

    AST_ACK_PULSE: assert property (@(posedge CLK) disable iff (!RST_N)
        WB_ACK |=> !WB_ACK)
        else $error("acknowledge longer than one cycle");

    AST_RDATA_IDLE: assert property (@(posedge CLK) disable iff (!RST_N)
        !WB_ACK |-> WB_DAT_R == 32'h0000_0000)
        else $error("read data not zero outside answer");

    AST_OSC_READ: assert property (@(posedge CLK) disable iff (!RST_N)
        osc_sync_q |-> pin_read[7:6] == 2'b00)
        else $error("oscillator pins read nonzero");

endmodule // pgas_port

// *** pgas_pins.sv ***
// Board model for the eight port pins: resolves each pin level.
// Assumes the device drives a pin only while its PIN_OE_N bit is low.

`timescale 1ns/100ps

module pgas_pins (
    // Clock
    input  wire logic       CLK,
    // Device side
    input  wire logic [7:0] PIN_OUT,
    input  wire logic [7:0] PIN_OE_N,
    // Board side
    input  wire logic [7:0] BRD_LVL,
    input  wire logic [7:0] BRD_EN,
    // Resolved levels
    output logic      [7:0] PIN_IN
);
    logic [7:0] flt_q = 8'h55;

    // Undriven lines other than the pulled-up pin 4 wander so a stale level never reads back
    always_ff @(posedge CLK) begin
        flt_q <= ~flt_q;
    end

    // Open-drain pin has a board pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!PIN_OE_N[i]) PIN_IN[i] = PIN_OUT[i];
            else if (BRD_EN[i]) PIN_IN[i] = BRD_LVL[i];
            else PIN_IN[i] = (i == 4) ? 1'b1 : flt_q[i];
        end
    end
endmodule // pgas_pins

// *** pgas_port_test.sv ***
// Self-checking bench for the port: table rows, then hand-written cases.
// Assumes the board model above and a one-cycle Wishbone answer.

`timescale 1ns/100ps

module pgas_port_test;
    typedef struct packed {
        logic [5:0] analog_select_bit;
        logic [7:0] dir, dat, brd;
        logic       osc;
        logic [7:0] oe, lvl, rd;
    } pgas_row_t;

    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, osc = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat_w = 32'h0, dat_r;
    logic        ack, tzc, mcl;
    logic [7:0]  pin_in, pin_out, pin_oe_n, brd = 8'h00, rd, brd_en = 8'hFF;
    logic [5:0]  asel;
    int          error_cnt = 0, samples_checked = 0;
    pgas_row_t   rows [6] = '{
        '{6'h00, 8'h00, 8'hA5, 8'h00, 1'b0, 8'h20, 8'h85, 8'h85},
        '{6'h00, 8'h00, 8'h5A, 8'h00, 1'b0, 8'h30, 8'h4A, 8'h4A},
        '{6'h0F, 8'hFF, 8'h00, 8'hFF, 1'b0, 8'hFF, 8'hFF, 8'hF0},
        '{6'h00, 8'hFF, 8'h00, 8'h3C, 1'b0, 8'hFF, 8'h3C, 8'h3C},
        '{6'h00, 8'h00, 8'hFF, 8'h00, 1'b1, 8'hF0, 8'h0F, 8'h0F},
        '{6'h0C, 8'h00, 8'h0F, 8'h00, 1'b0, 8'h20, 8'h0F, 8'h03}};

    pgas_port i_dut (.CLK(clk), .RST_N(rst_n), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we),
        .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_W(dat_w), .WB_DAT_R(dat_r), .WB_ACK(ack),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .OSC_OWNS_PINS(osc),
        .TIMER_ZERO_CLK(tzc), .MASTER_CLEAR_LEVEL(mcl), .ANALOG_SEL(asel));
    pgas_pins i_pins (.CLK(clk), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .BRD_LVL(brd),
        .BRD_EN(brd_en), .PIN_IN(pin_in));

    initial begin
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] idx, input logic [3:0] s,
                      input logic [15:0] wd, output logic [7:0] r);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; sel <= s;
        dat_w <= {16'h0, wd};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        r = dat_r[7:0];
        cyc <= 1'b0; stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, idx, 4'h1, {8'h00, d}, r);
    endtask

    task automatic conclude();
        $display("Checks made %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        error_cnt++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, pgas_pkg::IDX_PORT_PIN_DIRECTION, 4'h1, 16'h0, rd); chk(rd, 8'hFF);
        wb(1'b0, pgas_pkg::IDX_ANALOG_PIN_SELECT, 4'h1, 16'h0, rd); chk(rd, 8'h3F);
        wb(1'b0, pgas_pkg::IDX_PORT_PIN_DATA, 4'h1, 16'h0, rd); chk(rd[3:0], 4'h0);
        chk(pin_oe_n, 8'hFF);
        $display("Test reset done");
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            brd <= rows[i].brd; osc <= rows[i].osc;
            wr(pgas_pkg::IDX_ANALOG_PIN_SELECT, {2'b00, rows[i].analog_select_bit});
            wr(pgas_pkg::IDX_PORT_PIN_DIRECTION, rows[i].dir);
            wr(pgas_pkg::IDX_PORT_PIN_DATA, rows[i].dat);
            repeat (5) @(posedge clk);
            chk(pin_oe_n, rows[i].oe);
            chk(pin_in, rows[i].lvl);
            chk({mcl, tzc}, rows[i].lvl[5:4]);
            wb(1'b0, pgas_pkg::IDX_PORT_PIN_DATA, 4'h1, 16'h0, rd);
            chk(rd, rows[i].rd);
        end
        $display("Test table done");
        // Masked write merges sampled pins, input pin latch bit takes its pin level
        @(posedge clk);
        brd <= 8'h00; osc <= 1'b0;
        wr(pgas_pkg::IDX_ANALOG_PIN_SELECT, 8'h00);
        wr(pgas_pkg::IDX_PORT_PIN_DIRECTION, 8'hFF);
        wr(pgas_pkg::IDX_PORT_PIN_DATA, 8'hFF);
        wr(pgas_pkg::IDX_PORT_PIN_DIRECTION, 8'h01);
        repeat (4) @(posedge clk);
        wb(1'b1, pgas_pkg::IDX_PORT_PIN_DATA, 4'h3, 16'h0200, rd);
        wr(pgas_pkg::IDX_PORT_PIN_DIRECTION, 8'h00);
        repeat (4) @(posedge clk);
        wb(1'b0, pgas_pkg::IDX_PORT_PIN_DATA, 4'h1, 16'h0, rd); chk(rd, 8'hCC);
        $display("Test merge done");
        // Select register upper bits, unmapped place, disabled lane
        wr(pgas_pkg::IDX_ANALOG_PIN_SELECT, 8'hFF);
        wb(1'b0, pgas_pkg::IDX_ANALOG_PIN_SELECT, 4'h1, 16'h0, rd); chk(rd, 8'h3F);
        chk(asel, 6'h3F);
        wr(8'h40, 8'h5A);
        wb(1'b0, 8'h40, 4'h1, 16'h0, rd); chk(rd, 8'h00);
        wb(1'b1, pgas_pkg::IDX_PORT_PIN_DIRECTION, 4'h0, 16'h0055, rd);
        wb(1'b0, pgas_pkg::IDX_PORT_PIN_DIRECTION, 4'h1, 16'h0, rd); chk(rd, 8'h00);
        $display("Test access done");
        // Second reset in mid-run
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({pin_oe_n, 2'b00, asel}, {8'hFF, 8'h3F});
        wb(1'b0, pgas_pkg::IDX_PORT_PIN_DATA, 4'h1, 16'h0, rd); chk(rd[3:0], 4'h0);
        // Released open-drain pin rises on its pull-up
        brd_en <= 8'hEF;
        repeat (5) @(posedge clk);
        chk(tzc, 1'b1);
        wb(1'b0, pgas_pkg::IDX_PORT_PIN_DATA, 4'h1, 16'h0, rd); chk(rd[4], 1'b1);
        $display("Test second reset done");
        conclude();
    end
endmodule // pgas_port_test
